// ===== slcr_buf.sv
// packet buffer emptied by the core reset
module slcr_buf
    import slcr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic clear_i,
    // write side
    input wire slcr_beat_t wr_i,
    output logic wr_ready_o,
    // read side
    input wire logic rd_ready_i,
    output slcr_beat_t rd_o,
    output logic [SLCR_PTR_W:0] level_o
);

    // ----------------------------------------
    // storage and pointers
    // ----------------------------------------
    logic [SLCR_DATA_W-1:0] mem_r [SLCR_BUF_DEPTH];
    logic [SLCR_PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [SLCR_PTR_W:0] lvl_r, lvl_nxt;
    logic do_wr, do_rd;

    always_comb begin
        do_wr = wr_i.valid && (lvl_r != (SLCR_PTR_W+1)'(SLCR_BUF_DEPTH));
        do_rd = rd_ready_i && (lvl_r != SLCR_LVL_RST);
        wp_nxt = wp_r + SLCR_PTR_W'(do_wr);
        rp_nxt = rp_r + SLCR_PTR_W'(do_rd);
        lvl_nxt = lvl_r + (SLCR_PTR_W+1)'(do_wr) - (SLCR_PTR_W+1)'(do_rd);
        if (clear_i) begin
            // clearing drops every stored entry
            wp_nxt = SLCR_PTR_RST;
            rp_nxt = SLCR_PTR_RST;
            lvl_nxt = SLCR_LVL_RST;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        wp_r <= wp_nxt;
        rp_r <= rp_nxt;
        lvl_r <= lvl_nxt;
        if (do_wr && !clear_i) begin
            mem_r[wp_r] <= wr_i.data;
        end
    end

    always_comb begin
        wr_ready_o = !clear_i && (lvl_r != (SLCR_PTR_W+1)'(SLCR_BUF_DEPTH));
        rd_o.valid = !clear_i && (lvl_r != SLCR_LVL_RST);
        rd_o.data = rd_o.valid ? mem_r[rp_r] : '0;
        level_o = lvl_r;
    end

endmodule

// ===== slcr_core.sv
// reset sequencer of the serial link core with its transmit and receive buffers
// Notes on behaviour
// - The core takes one active-low main reset and, on newer families, a management-domain reset.
// - The main reset resets the whole core, and with the management reset its transceiver logic.
// - During reset every wait-request output is high and every other output is low.
// - After a main reset every packet buffer is empty; a management reset alone keeps the buffered data but clears both output registers.
module slcr_core
    import slcr_pkg::*;
(
    // clock and resets
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic main_rst_n_i,
    input wire logic mgmt_rst_i,
    // transmit path
    input wire slcr_beat_t tx_in_i,
    output logic tx_in_ready_o,
    input wire logic tx_out_ready_i,
    output slcr_beat_t tx_out_o,
    // receive path
    input wire slcr_beat_t rx_in_i,
    output logic rx_in_ready_o,
    input wire logic rx_out_ready_i,
    output slcr_beat_t rx_out_o,
    // memory-mapped port handshakes
    input wire logic [SLCR_NUM_MM-1:0] mm_req_i,
    output logic [SLCR_NUM_MM-1:0] mm_waitrequest_o,
    // status
    output slcr_rst_t status_o,
    output logic [SLCR_PTR_W:0] tx_level_o,
    output logic [SLCR_PTR_W:0] rx_level_o
);

    // ----------------------------------------
    // reset sources
    // ----------------------------------------
    logic core_rst, mgmt_rst, in_reset;
    slcr_state_t st_r, st_nxt;
    logic [SLCR_CNT_W-1:0] cnt_r, cnt_nxt;

    function automatic logic beat_ok(input slcr_beat_t b, input logic rdy);
        beat_ok = b.valid && rdy;
    endfunction

    always_comb begin
        core_rst = reset_i || !main_rst_n_i;
        mgmt_rst = core_rst || mgmt_rst_i;
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        if (core_rst) begin
            // any main reset restarts the whole core
            st_nxt = SLCR_ST_HOLD;
            cnt_nxt = SLCR_CNT_RST;
        end else begin
            unique case (st_r)
                SLCR_ST_HOLD: begin
                    st_nxt = SLCR_ST_FLUSH;
                    cnt_nxt = SLCR_CNT_RST;
                end
                SLCR_ST_FLUSH: begin
                    cnt_nxt = cnt_r + SLCR_CNT_W'(1);
                    if (cnt_r == SLCR_CNT_W'(SLCR_MIN_RESET_CYC - 1)) begin
                        st_nxt = SLCR_ST_RUN;
                    end
                end
                SLCR_ST_RUN: begin
                    st_nxt = SLCR_ST_RUN;
                end
                default: begin
                    st_nxt = SLCR_ST_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        st_r <= st_nxt;
        cnt_r <= cnt_nxt;
    end

    always_comb begin
        in_reset = core_rst || (st_r != SLCR_ST_RUN);
    end

    // ----------------------------------------
    // packet buffers
    // ----------------------------------------
    slcr_beat_t tx_rd, rx_rd;
    logic tx_wr_rdy, rx_wr_rdy;
    logic [SLCR_PTR_W:0] tx_lvl, rx_lvl;
    slcr_beat_t tx_wr, rx_wr;

    always_comb begin
        tx_wr.valid = beat_ok(tx_in_i, tx_in_ready_o) && !in_reset;
        tx_wr.data = tx_in_i.data;
        rx_wr.valid = beat_ok(rx_in_i, rx_in_ready_o) && !in_reset;
        rx_wr.data = rx_in_i.data;
    end

    slcr_buf u_tx_buf (
        .sys_clk_i(sys_clk_i),
        .clear_i(in_reset),
        .wr_i(tx_wr),
        .wr_ready_o(tx_wr_rdy),
        // pop only when the output register takes the head
        .rd_ready_i((!tx_out_o.valid || tx_out_ready_i) && !in_reset && !mgmt_rst),
        .rd_o(tx_rd),
        .level_o(tx_lvl)
    );

    slcr_buf u_rx_buf (
        .sys_clk_i(sys_clk_i),
        .clear_i(in_reset),
        .wr_i(rx_wr),
        .wr_ready_o(rx_wr_rdy),
        // pop only when the output register takes the head
        .rd_ready_i((!rx_out_o.valid || rx_out_ready_i) && !in_reset && !mgmt_rst),
        .rd_o(rx_rd),
        .level_o(rx_lvl)
    );

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    slcr_beat_t tx_out_r, tx_out_nxt, rx_out_r, rx_out_nxt;
    logic tx_rdy_r, tx_rdy_nxt, rx_rdy_r, rx_rdy_nxt;
    logic [SLCR_NUM_MM-1:0] wait_r, wait_nxt;
    slcr_rst_t stat_r, stat_nxt;
    logic [SLCR_PTR_W:0] txl_r, txl_nxt, rxl_r, rxl_nxt;
    logic tx_pop, rx_pop;

    always_comb begin
        tx_pop = tx_out_r.valid && tx_out_ready_i;
        rx_pop = rx_out_r.valid && rx_out_ready_i;
        tx_out_nxt = tx_out_r;
        rx_out_nxt = rx_out_r;
        if (!tx_out_r.valid || tx_pop) begin
            tx_out_nxt = tx_rd;
        end
        if (!rx_out_r.valid || rx_pop) begin
            rx_out_nxt = rx_rd;
        end
        tx_rdy_nxt = tx_wr_rdy;
        rx_rdy_nxt = rx_wr_rdy;
        wait_nxt = ~mm_req_i;
        stat_nxt.core_rst = 1'b0;
        stat_nxt.mgmt_rst = 1'b0;
        stat_nxt.ready = 1'b1;
        txl_nxt = tx_lvl;
        rxl_nxt = rx_lvl;
        if (in_reset || mgmt_rst) begin
            // wait-requests high, all else low
            tx_out_nxt = '0;
            rx_out_nxt = '0;
            tx_rdy_nxt = 1'b0;
            rx_rdy_nxt = 1'b0;
            wait_nxt = '1;
            stat_nxt = '0;
            txl_nxt = SLCR_LVL_RST;
            rxl_nxt = SLCR_LVL_RST;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        tx_out_r <= tx_out_nxt;
        rx_out_r <= rx_out_nxt;
        tx_rdy_r <= tx_rdy_nxt;
        rx_rdy_r <= rx_rdy_nxt;
        wait_r <= wait_nxt;
        stat_r <= stat_nxt;
        txl_r <= txl_nxt;
        rxl_r <= rxl_nxt;
    end

    always_comb begin
        tx_out_o = tx_out_r;
        rx_out_o = rx_out_r;
        tx_in_ready_o = tx_rdy_r;
        rx_in_ready_o = rx_rdy_r;
        mm_waitrequest_o = wait_r;
        status_o = stat_r;
        tx_level_o = txl_r;
        rx_level_o = rxl_r;
    end

endmodule

// ===== slcr_core_asserts.sv
// checker of reset behaviour at the core ports
module slcr_core_asserts
    import slcr_pkg::*;
(
    // clock and resets
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic main_rst_n_i,
    input wire logic mgmt_rst_i,
    // watched outputs
    input wire logic tx_in_ready_o,
    input wire slcr_beat_t tx_out_o,
    input wire logic rx_in_ready_o,
    input wire slcr_beat_t rx_out_o,
    input wire logic [SLCR_NUM_MM-1:0] mm_waitrequest_o,
    input wire slcr_rst_t status_o,
    input wire logic [SLCR_PTR_W:0] tx_level_o,
    input wire logic [SLCR_PTR_W:0] rx_level_o
);
    property p_sys_view;
        @(posedge sys_clk_i) reset_i |=> mm_waitrequest_o == '1 && status_o == '0
            && !tx_in_ready_o && !rx_in_ready_o && !tx_out_o.valid && !rx_out_o.valid;
    endproperty
    a_sys_view: assert property (p_sys_view) else $error("not in reset view");
    property p_main_view;
        @(posedge sys_clk_i) !main_rst_n_i |=> mm_waitrequest_o == '1 && tx_out_o == '0
            && rx_out_o == '0 && tx_level_o == '0 && rx_level_o == '0;
    endproperty
    a_main_view: assert property (p_main_view) else $error("main reset ignored");
    property p_mgmt_view;
        @(posedge sys_clk_i) mgmt_rst_i |=> mm_waitrequest_o == '1 && !status_o.ready;
    endproperty
    a_mgmt_view: assert property (p_mgmt_view) else $error("mgmt reset ignored");
    property p_exit_empty;
        @(posedge sys_clk_i) disable iff (reset_i) $rose(status_o.ready) |-> tx_level_o == '0
            && rx_level_o == '0 && !tx_out_o.valid && !rx_out_o.valid;
    endproperty
    a_exit_empty: assert property (p_exit_empty) else $error("buffer not empty");
endmodule

bind slcr_core slcr_core_asserts slcr_core_asserts_inst (.sys_clk_i, .reset_i, .main_rst_n_i,
    .mgmt_rst_i, .tx_in_ready_o, .tx_out_o, .rx_in_ready_o, .rx_out_o, .mm_waitrequest_o,
    .status_o, .tx_level_o, .rx_level_o);

// ===== slcr_core_bench.sv
// self-checking bench of the core reset sequencer
module slcr_core_bench import slcr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic rst_req = 1'b1;
    logic main_rst_n, mgmt_rst, tx_in_rdy, rx_in_rdy;
    logic tx_out_rdy = 1'b0;
    logic rx_out_rdy = 1'b0;
    slcr_beat_t tx_in = '0;
    slcr_beat_t rx_in = '0;
    slcr_beat_t tx_out, rx_out;
    logic [SLCR_NUM_MM-1:0] mm_req = '0;
    logic [SLCR_NUM_MM-1:0] mm_wait;
    slcr_rst_t status;
    logic [SLCR_PTR_W:0] tx_lvl, rx_lvl;
    logic [31:0] seed = 32'hbe48;
    logic [31:0] exp_q[$];
    logic [31:0] rx_q[$];
    logic [SLCR_NUM_MM-1:0] req_q;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    slcr_rst_src slcr_rst_src_inst (.sys_clk_i(sys_clk_i), .rst_req_i(rst_req),
        .main_rst_n_o(main_rst_n), .mgmt_rst_o(mgmt_rst));
    slcr_core slcr_core_inst (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .main_rst_n_i(main_rst_n), .mgmt_rst_i(mgmt_rst), .tx_in_i(tx_in),
        .tx_in_ready_o(tx_in_rdy), .tx_out_ready_i(tx_out_rdy), .tx_out_o(tx_out),
        .rx_in_i(rx_in), .rx_in_ready_o(rx_in_rdy), .rx_out_ready_i(rx_out_rdy),
        .rx_out_o(rx_out), .mm_req_i(mm_req), .mm_waitrequest_o(mm_wait),
        .status_o(status), .tx_level_o(tx_lvl), .rx_level_o(rx_lvl));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic reset_view();
        return mm_wait === '1 && tx_out === '0 && rx_out === '0 && status === '0
            && tx_in_rdy === 1'b0 && rx_in_rdy === 1'b0 && tx_lvl === '0 && rx_lvl === '0;
    endfunction
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            wrap_up();
        end
    end
    // scoreboard of the transmit and receive paths and the wait-requests
    always @(posedge sys_clk_i) begin
        if (tx_out.valid === 1'b1 && tx_out_rdy) begin
            chk(exp_q.size() > 0 && tx_out.data === exp_q[0], "tx beat");
            if (exp_q.size() > 0) void'(exp_q.pop_front());
        end
        if (tx_in.valid && tx_in_rdy === 1'b1) exp_q.push_back(tx_in.data);
        if (rx_out.valid === 1'b1 && rx_out_rdy) begin
            chk(rx_q.size() > 0 && rx_out.data === rx_q[0], "rx beat");
            if (rx_q.size() > 0) void'(rx_q.pop_front());
        end
        if (rx_in.valid && rx_in_rdy === 1'b1) rx_q.push_back(rx_in.data);
        if (status.ready === 1'b1) chk(mm_wait === ~req_q, "waitrequest");
        req_q = mm_req;
    end
    task automatic wait_run();
        int n;
        n = 0;
        while (status.ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk_i);
            n++;
        end
        chk(n < 20, "no exit from reset");
    endtask
    task automatic push(input int n);
        repeat (n) begin
            @(negedge sys_clk_i);
            seed = lfsr(seed);
            tx_in <= '{valid: 1'b1, data: seed};
            rx_in <= '{valid: 1'b1, data: ~seed};
            mm_req <= seed[1:0];
            rx_out_rdy <= seed[2];
        end
        @(negedge sys_clk_i);
        tx_in.valid <= 1'b0;
        rx_in.valid <= 1'b0;
    endtask
    task automatic core_reset(input logic by_src);
        if (by_src) rst_req <= 1'b1; else reset_i <= 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk(reset_view(), "no reset view");
        if (by_src) rst_req <= 1'b0; else reset_i <= 1'b0;
        exp_q.delete();
        rx_q.delete();
        wait_run();
        chk(tx_lvl === '0 && rx_lvl === '0 && tx_out.valid === 1'b0
            && rx_out.valid === 1'b0, "not empty");
    endtask
    initial begin
        repeat (20) @(negedge sys_clk_i);
        chk(reset_view(), "no reset view");
        reset_i <= 1'b0;
        rst_req <= 1'b0;
        wait_run();
        for (int i = 0; i < 4; i++) begin
            push(3 + 4 * i);
            repeat (2) @(negedge sys_clk_i);
            // one beat of the burst already sits in the output register
            chk(tx_lvl === 5'(2 + 4 * i), "tx level");
            core_reset(i[0]);
            tx_out_rdy <= 1'b1;
            push(4);
            rx_out_rdy <= 1'b1;
            repeat (10) @(negedge sys_clk_i);
            chk(exp_q.size() == 0, "tx beats lost");
            chk(rx_q.size() == 0, "rx beats lost");
            tx_out_rdy <= 1'b0;
        end
        wrap_up();
    end
endmodule

// ===== slcr_pkg.sv
// package: constants, states and carriers for the serial link core reset block
package slcr_pkg;

    // ----------------------------------------
    // widths and timing
    // ----------------------------------------
    localparam int SLCR_CLK_HZ = 20_000_000;
    localparam int SLCR_MIN_RESET_NS = 50;
    localparam int SLCR_MIN_RESET_CYC =
        (SLCR_MIN_RESET_NS * (SLCR_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int SLCR_BUF_DEPTH = 16;
    localparam int SLCR_PTR_W = 4;
    localparam int SLCR_DATA_W = 32;
    localparam int SLCR_NUM_MM = 2;
    localparam int SLCR_FLUSH_CYC = 16;
    localparam int SLCR_CNT_W = 5;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [SLCR_PTR_W-1:0] SLCR_PTR_RST = 4'h0;
    localparam logic [SLCR_PTR_W:0] SLCR_LVL_RST = 5'h00;
    localparam logic [SLCR_CNT_W-1:0] SLCR_CNT_RST = 5'h00;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [1:0] {
        SLCR_ST_HOLD,
        SLCR_ST_FLUSH,
        SLCR_ST_RUN
    } slcr_state_t;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic [SLCR_DATA_W-1:0] data;
    } slcr_beat_t;

    typedef struct packed {
        logic core_rst;
        logic mgmt_rst;
        logic ready;
    } slcr_rst_t;

endpackage

// ===== slcr_rst_src.sv
// reset source model: asserts at once, releases through two flops
module slcr_rst_src (
    // clock and request
    input wire logic sys_clk_i,
    input wire logic rst_req_i,
    // resets to the core
    output logic main_rst_n_o,
    output logic mgmt_rst_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] sync_r;
    always_ff @(posedge sys_clk_i or posedge rst_req_i) begin
        if (rst_req_i) begin
            sync_r <= 2'h0;
        end else begin
            sync_r <= {sync_r[0], 1'b1};
        end
    end
    // one origin and one clock for both resets
    assign main_rst_n_o = sync_r[1];
    assign mgmt_rst_o = ~sync_r[1];
endmodule
